// ### src/misc_exec_pkg.sv
// package of constants and types for the miscellaneous instruction executor
// ==========================================================================
`default_nettype none
package misc_exec_pkg;

	// ======================================================================
	// register map
	localparam logic [7:0] OFS_CTRL       = 8'h00; // instruction issue
	localparam logic [7:0] OFS_ACC        = 8'h04; // accumulator
	localparam logic [7:0] OFS_TIMER_CFG  = 8'h08; // timer configuration (ro)
	localparam logic [7:0] OFS_STATUS     = 8'h0c; // carry, power-down, time-out, halt, busy
	localparam logic [7:0] OFS_PC         = 8'h10; // program counter
	localparam logic [7:0] OFS_STACK      = 8'h14; // push value / read head
	localparam logic [7:0] OFS_POWER_CTRL = 8'h18; // power control register
	localparam logic [7:0] OFS_FILE       = 8'h1c; // file register window
	localparam logic [7:0] OFS_WATCHDOG   = 8'h20; // watchdog counter/prescaler

	// ctrl word fields
	localparam int CTRL_OP_LSB   = 0;  // 3-bit opcode
	localparam int CTRL_ADDR_LSB = 4;  // 7-bit file address
	localparam int CTRL_DEST_BIT = 11; // destination selector
	localparam int FILE_DATA_LSB = 0;  // file window data
	localparam int FILE_ADDR_LSB = 8;  // file window address

	// status and power control bit positions
	localparam int ST_CARRY       = 0;
	localparam int ST_POWERDOWN   = 1;
	localparam int ST_TIMEOUT     = 2;
	localparam int ST_SLEEP       = 3;
	localparam int ST_BUSY        = 4;
	localparam int PWR_RESET_FLAG = 0;

	// reset values and return cycle count
	localparam logic [7:0]  TIMER_CFG_RST  = 8'hff;
	localparam logic [7:0]  ACC_RST        = 8'h00;
	localparam logic        CARRY_RST      = 1'b0;
	localparam logic        TIMEOUT_RST    = 1'b1;
	localparam logic        POWERDOWN_RST  = 1'b1;
	localparam logic        RESET_FLAG_RST = 1'b1;
	localparam logic [7:0]  WATCHDOG_RST   = 8'h00;
	localparam int          RETURN_CYCLES  = 2;

	typedef enum logic [2:0] {
		OP_NOP      = 3'b000,
		OP_CFG_LOAD = 3'b001,
		OP_SW_RESET = 3'b010,
		OP_RETURN   = 3'b011,
		OP_ROT_R    = 3'b100,
		OP_ROT_L    = 3'b101,
		OP_SLEEP    = 3'b110
	} op_t;

	typedef enum logic [1:0] {
		ST_RUN    = 2'b00,
		ST_RET2   = 2'b01,
		ST_HALTED = 2'b10
	} exec_state_t;

	// decoded instruction
	typedef struct packed {
		op_t        op;
		logic [6:0] addr;
		logic       dest;
	} instr_t;

	// rotate result with carry out
	typedef struct packed {
		logic [7:0] value;
		logic       carry;
	} rot_t;

endpackage : misc_exec_pkg
`default_nettype wire

// ### src/misc_instruction_exec.sv
// miscellaneous instruction executor with an ahb-lite register slave
`timescale 1ns/1ps
`default_nettype none
module misc_instruction_exec
	import misc_exec_pkg::*;
#(
	parameter int STACK_DEPTH = 16,
	parameter int PC_WIDTH    = 12
) (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// core side
	output logic             device_reset_req,
	output logic             osc_stop
);

	// refuse sizes the stack pointer and program counter cannot serve
	if (STACK_DEPTH < 2 || STACK_DEPTH > 256) begin : g_bad_depth
		$error("bad STACK_DEPTH");
	end
	if (PC_WIDTH < 1 || PC_WIDTH > 16) begin : g_bad_pc
		$error("bad PC_WIDTH");
	end
	// the sequencer holds exactly one extra state for a return
	if (RETURN_CYCLES != 2) begin : g_bad_return
		$error("return sequencer built for two cycles");
	end

	localparam int SPW = $clog2(STACK_DEPTH);

	// ======================================================================
	// functions
	function automatic rot_t rotate(input logic [7:0] v, input logic c, input logic left);
		rot_t r;
		if (left) r = '{value: {v[6:0], c}, carry: v[7]};
		else r = '{value: {c, v[7:1]}, carry: v[0]};
		return r;
	endfunction : rotate

	// ======================================================================
	// state
	logic [7:0]          acc;
	logic [7:0]          timer_cfg;
	logic                carry;
	logic                timeout_status_bit;
	logic                powerdown_status_bit;
	logic                reset_instruction_flag;
	logic [7:0]          watchdog_counter;
	logic [7:0]          watchdog_prescaler;
	logic [PC_WIDTH-1:0] pc;
	logic [PC_WIDTH-1:0] stack_mem [STACK_DEPTH];
	logic [SPW:0]        sp;
	logic [7:0]          file_mem [128];
	exec_state_t         state;

	// ======================================================================
	// bus address phase capture
	logic       dp_valid;
	logic       dp_write;
	logic [7:0] dp_addr;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_valid <= 1'b0;
			dp_write <= 1'b0;
			dp_addr  <= 8'h00;
		end else if (hready) begin
			dp_valid <= hsel && htrans[1];
			dp_write <= hwrite;
			dp_addr  <= haddr[7:0];
		end
	end

	wire logic   wr = dp_valid && dp_write;
	wire instr_t ins = '{op: op_t'(hwdata[CTRL_OP_LSB +: 3]),
		addr: hwdata[CTRL_ADDR_LSB +: 7], dest: hwdata[CTRL_DEST_BIT]};
	wire logic   issue = wr && dp_addr == OFS_CTRL && state == ST_RUN;
	wire logic   stack_empty = (sp == '0);
	wire logic [SPW-1:0] head_idx = SPW'(sp - 1'b1);
	wire rot_t   rot_res = rotate(file_mem[ins.addr], carry, ins.op == OP_ROT_L);
	wire logic   is_rot = issue && (ins.op == OP_ROT_R || ins.op == OP_ROT_L);

	// always ready, always okay
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// read mux, registered for the data phase
	logic [31:0] next_rdata;
	always_comb begin
		next_rdata = 32'h0000_0000;
		case (haddr[7:0])
			OFS_ACC:       next_rdata = {24'h000000, acc};
			OFS_TIMER_CFG: next_rdata = {24'h000000, timer_cfg};
			OFS_STATUS:    next_rdata = {27'h0000000, state == ST_RET2,
				state == ST_HALTED, timeout_status_bit, powerdown_status_bit, carry};
			OFS_PC:        next_rdata = 32'(pc);
			OFS_STACK:     next_rdata = stack_empty ? 32'h0 : 32'(stack_mem[head_idx]);
			OFS_POWER_CTRL: next_rdata = {31'h0, reset_instruction_flag};
			OFS_WATCHDOG:  next_rdata = {16'h0000, watchdog_prescaler, watchdog_counter};
			default:       next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) hrdata <= 32'h0000_0000;
		else if (hready && hsel && htrans[1] && !hwrite) hrdata <= next_rdata;
	end

	// ======================================================================
	// execution sequencer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= ST_RUN;
		end else begin
			case (state)
				ST_RUN: begin
					if (issue && ins.op == OP_RETURN) state <= ST_RET2;
					else if (issue && ins.op == OP_SLEEP) state <= ST_HALTED;
				end
				ST_RET2: state <= ST_RUN;
				ST_HALTED: state <= ST_HALTED;
				default: state <= ST_RUN;
			endcase
		end
	end

	// program counter and return stack
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pc <= '0;
			sp <= '0;
		end else if (wr && dp_addr == OFS_STACK && state == ST_RUN) begin
			if (sp != (SPW+1)'(STACK_DEPTH)) sp <= sp + 1'b1;
		end else if (issue && ins.op == OP_RETURN) begin
			pc <= stack_empty ? pc : stack_mem[head_idx];
			sp <= stack_empty ? sp : sp - 1'b1;
		end else if (issue && ins.op != OP_SW_RESET) begin
			pc <= pc + 1'b1;
		end else if (wr && dp_addr == OFS_PC && state == ST_RUN) begin
			pc <= hwdata[PC_WIDTH-1:0];
		end
	end

	// return stack storage, push ignored when full (no reset on storage)
	always_ff @(posedge hclk) begin
		if (wr && dp_addr == OFS_STACK && state == ST_RUN && sp != (SPW+1)'(STACK_DEPTH))
			stack_mem[sp[SPW-1:0]] <= hwdata[PC_WIDTH-1:0];
	end

	// accumulator and carry registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acc   <= ACC_RST;
			carry <= CARRY_RST;
		end else if (is_rot) begin
			carry <= rot_res.carry;
			if (!ins.dest) acc <= rot_res.value;
		end else if (wr && dp_addr == OFS_ACC && state == ST_RUN) begin
			acc <= hwdata[7:0];
		end else if (wr && dp_addr == OFS_STATUS && state == ST_RUN) begin
			carry <= hwdata[ST_CARRY];
		end
	end

	// file array write path (no reset on storage)
	always_ff @(posedge hclk) begin
		if (is_rot && ins.dest) file_mem[ins.addr] <= rot_res.value;
		else if (wr && dp_addr == OFS_FILE && state == ST_RUN)
			file_mem[hwdata[FILE_ADDR_LSB +: 7]] <= hwdata[FILE_DATA_LSB +: 8];
	end

	// timer configuration load
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) timer_cfg <= TIMER_CFG_RST;
		else if (issue && ins.op == OP_CFG_LOAD) timer_cfg <= acc;
	end

	// sleep side effects on watchdog and status bits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			watchdog_counter     <= WATCHDOG_RST;
			watchdog_prescaler   <= WATCHDOG_RST;
			timeout_status_bit   <= TIMEOUT_RST;
			powerdown_status_bit <= POWERDOWN_RST;
		end else if (issue && ins.op == OP_SLEEP) begin
			watchdog_counter     <= 8'h00;
			watchdog_prescaler   <= 8'h00;
			powerdown_status_bit <= 1'b0;
			timeout_status_bit   <= 1'b1;
		end else if (state != ST_HALTED) begin
			{watchdog_counter, watchdog_prescaler} <= {watchdog_counter, watchdog_prescaler} + 16'h0001;
		end
	end

	// power control reset-instruction flag and reset request
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			reset_instruction_flag <= RESET_FLAG_RST;
			device_reset_req       <= 1'b0;
			osc_stop               <= 1'b0;
		end else begin
			if (issue && ins.op == OP_SW_RESET) begin
				reset_instruction_flag <= 1'b0;
				device_reset_req       <= 1'b1;
			end else if (wr && dp_addr == OFS_POWER_CTRL) begin
				reset_instruction_flag <= reset_instruction_flag | hwdata[PWR_RESET_FLAG];
			end
			if (issue && ins.op == OP_SLEEP) osc_stop <= 1'b1;
		end
	end

endmodule : misc_instruction_exec
`default_nettype wire

// ### verification/misc_instruction_exec_assertions.sv
// port assertions for the instruction executor
`timescale 1ns/1ps
`default_nettype none
module misc_exec_checker
	import misc_exec_pkg::*;
(
	// clock, reset and bus
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// core side
	input wire logic        device_reset_req,
	input wire logic        osc_stop
);
	logic       wr_q;
	logic       rd_q;
	logic [7:0] a_q;
	logic       ret_q;
	// ====================================================
	// data phase tracking
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			a_q  <= 8'h00;
		end else if (hready) begin
			wr_q <= hsel && htrans[1] && hwrite;
			rd_q <= hsel && htrans[1] && !hwrite;
			a_q  <= haddr[7:0];
		end
	end
	wire logic ctrl = wr_q && (a_q == OFS_CTRL);
	// a control write counts only outside the return's second cycle and halt
	wire logic live = ctrl && !ret_q && !osc_stop;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) ret_q <= 1'b0;
		else ret_q <= live && hwdata[2:0] == OP_RETURN;
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ====================================================
	// checks
	a_sleep_stop: assert property (live && hwdata[2:0] == OP_SLEEP |=> osc_stop)
		else $error("sleep left oscillator running");
	a_stop_held: assert property (osc_stop |=> osc_stop)
		else $error("oscillator restarted");
	a_no_stop: assert property (ctrl && (ret_q || hwdata[2:0] != OP_SLEEP) && !osc_stop
		|=> !osc_stop)
		else $error("oscillator stopped without sleep");
	a_reset_req: assert property (live && hwdata[2:0] == OP_SW_RESET |=> device_reset_req)
		else $error("software reset not requested");
	a_req_held: assert property (device_reset_req |=> device_reset_req)
		else $error("reset request dropped");
	a_sleep_flags: assert property (rd_q && a_q == OFS_STATUS && $past(osc_stop)
		|-> hrdata[ST_TIMEOUT] && !hrdata[ST_POWERDOWN] && hrdata[ST_SLEEP])
		else $error("status bits wrong after sleep");
	a_unmapped: assert property (rd_q && a_q == 8'h24 |-> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("wait state or error response");
endmodule : misc_exec_checker
bind misc_instruction_exec misc_exec_checker chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans,
	.hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .device_reset_req,
	.osc_stop);
`default_nettype wire

// ### verification/misc_instruction_exec_tb.sv
// testbench for the instruction executor
`timescale 1ns/1ps
`default_nettype none
module misc_instruction_exec_tb;
	import misc_exec_pkg::*;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic        device_reset_req, osc_stop;
	logic [31:0] haddr, hwdata, hrdata, rd, exp_pc;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	int          failures, total_checks;
	wire logic   hready = hreadyout;
	op_t         rop[3]  = '{OP_ROT_L, OP_ROT_R, OP_ROT_R};
	logic        rdst[3] = '{1'b0, 1'b1, 1'b0};
	logic [7:0]  racc[3] = '{8'hcc, 8'hcc, 8'h79};
	logic        rcar[3] = '{1'b1, 1'b0, 1'b1};
	misc_instruction_exec dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready, .hrdata, .hreadyout, .hresp, .device_reset_req, .osc_stop);
	// ====================================================
	// clock and watchdog
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	initial begin
		#200000;
		failures++;
		wrap_up();
	end
	// ====================================================
	// tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : xfer
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rchk
	task automatic exec(input op_t op, input logic [6:0] a, input logic dst);
		xfer(1'b1, OFS_CTRL, {20'h0, dst, a, 1'b0, op});
		@(posedge hclk); // idle so the effect lands
		if (op != OP_RETURN && op != OP_SW_RESET) exp_pc++;
	endtask : exec
	task automatic do_reset();
		hresetn <= 1'b0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		exp_pc = 32'h0;
	endtask : do_reset
	task automatic wrap_up();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : wrap_up
	// ====================================================
	// main sequence
	initial begin
		{hresetn, hsel, hwrite, haddr, hwdata, htrans} = '0;
		hsize = 3'b010;
		@(posedge hclk);
		do_reset();
		rchk(OFS_TIMER_CFG, 32'hff);
		rchk(OFS_POWER_CTRL, 32'h1);
		rchk(8'h24, 32'h0);
		xfer(1'b1, OFS_ACC, 32'h4f);
		exec(OP_CFG_LOAD, 7'h0, 1'b0);
		rchk(OFS_TIMER_CFG, 32'h4f);
		rchk(OFS_STATUS, 32'h6);
		exec(OP_NOP, 7'h0, 1'b0);
		exec(op_t'(3'h7), 7'h0, 1'b0);
		rchk(OFS_PC, exp_pc);
		xfer(1'b1, OFS_FILE, 32'h7fe6);
		xfer(1'b1, OFS_STATUS, 32'h0);
		for (int i = 0; i < 3; i++) begin
			exec(rop[i], 7'h7f, rdst[i]);
			rchk(OFS_ACC, {24'h0, racc[i]});
			rchk(OFS_STATUS, {29'h0, 2'b11, rcar[i]});
		end
		rchk(OFS_PC, exp_pc);
		xfer(1'b1, OFS_STACK, 32'h123);
		xfer(1'b1, OFS_CTRL, {29'h0, OP_RETURN});
		rchk(OFS_STATUS, 32'h17);
		rchk(OFS_STATUS, 32'h7);
		rchk(OFS_PC, 32'h123);
		rchk(OFS_STACK, 32'h0);
		exec(OP_SW_RESET, 7'h0, 1'b0);
		chk({31'h0, device_reset_req}, 32'h1);
		rchk(OFS_POWER_CTRL, 32'h0);
		xfer(1'b1, OFS_POWER_CTRL, 32'h1);
		rchk(OFS_POWER_CTRL, 32'h1);
		do_reset();
		chk({31'h0, device_reset_req}, 32'h0);
		exec(OP_SLEEP, 7'h0, 1'b0);
		chk({31'h0, osc_stop}, 32'h1);
		rchk(OFS_WATCHDOG, 32'h0);
		rchk(OFS_STATUS, 32'hc);
		exec(OP_CFG_LOAD, 7'h0, 1'b0);
		rchk(OFS_TIMER_CFG, 32'hff);
		wrap_up();
	end
endmodule : misc_instruction_exec_tb
`default_nettype wire
